/* adc_ctrl_defines.svh */
// offsets, codes, reset values and cycle counts of the converter control
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

// serial frame
`define FRAME_BITS      5'd16
`define FRAME_LAST      5'd15
`define TGT_HI_BIT      15
`define TGT_LO_BIT      14
`define DATA_MSB        13

// write targets held in the two leading frame bits
`define TGT_NONE        2'b00
`define TGT_TEST        2'b01
`define TGT_CAL         2'b10
`define TGT_CTRL        2'b11

// read targets
`define RD_RESULT       2'b00
`define RD_TEST         2'b01
`define RD_CAL          2'b10
`define RD_STATUS       2'b11

// calibration picks
`define PICK_FULL       2'b00
`define PICK_GAIN_OFFS  2'b01
`define PICK_OFFS       2'b10
`define PICK_GAIN       2'b11

// reset values
`define CTRL_RESET      14'h0000
`define STATUS_RESET    16'h0000
`define TEST_RESET      14'h0000
`define COEF_RESET      14'h0000

// activity lengths in clk_sys_i cycles
`define CONV_CYCLES     32
`define CAL_STEP_CYCLES 256
`define SEQ_CNT_W       16

`endif

/* adc_ctrl_pkg.sv */
// types shared by the converter control blocks
package adc_ctrl_pkg;

  typedef struct packed {
    logic [3:0] zeros;
    logic       power_mode_sel_hi;
    logic       power_mode_sel_lo;
    logic       read_target_hi;
    logic       read_target_lo;
    logic       iface_mode1;
    logic       single_conversion_go;
    logic       calibration_kind;
    logic       calibration_pick_hi;
    logic       calibration_pick_lo;
    logic       calibration_go;
  } control_word_t;

  typedef struct packed {
    logic       zero_top;
    logic       busy;
    logic [3:0] zeros;
    logic       power_mode_sel_hi;
    logic       power_mode_sel_lo;
    logic       read_target_hi;
    logic       read_target_lo;
    logic       iface_mode1;
    logic       dont_care;
    logic       calibration_kind;
    logic       calibration_pick_hi;
    logic       calibration_pick_lo;
    logic       calibration_go;
  } status_word_t;

  typedef enum logic [4:0] {
    SEQ_IDLE   = 5'b00001,
    SEQ_CONV   = 5'b00010,
    SEQ_DAC    = 5'b00100,
    SEQ_GAIN   = 5'b01000,
    SEQ_OFFSET = 5'b10000
  } seq_state_t;

endpackage

/* activity_sequencer.sv */
// conversion and calibration step sequencer
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defines.svh"
module activity_sequencer
  import adc_ctrl_pkg::*;
#(
  parameter int CONV_CYCLES = `CONV_CYCLES,
  parameter int STEP_CYCLES = `CAL_STEP_CYCLES,
  parameter int CNT_W       = `SEQ_CNT_W
) (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  // requests
  input  wire logic       conv_start_i,
  input  wire logic       cal_start_i,
  input  wire logic [1:0] cal_pick_i,
  // activity
  output seq_state_t      state_o,
  output logic            busy_o,
  output logic            conv_done_o,
  output logic            cal_done_o
);
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYCLES - 1);

  seq_state_t       state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [1:0]       pick_reg, pick_next;
  logic             busy_reg, busy_next;
  logic             last;

  always_comb begin
    state_next  = state_reg;
    pick_next   = pick_reg;
    cnt_next    = cnt_reg - CNT_W'(1);
    last        = (cnt_reg == '0);
    conv_done_o = 1'b0;
    cal_done_o  = 1'b0;
    case (state_reg)
      SEQ_IDLE: begin
        cnt_next = cnt_reg;
        if (cal_start_i) begin
          pick_next = cal_pick_i;
          cnt_next  = STEP_LAST;
          case (cal_pick_i)
            `PICK_FULL: state_next = SEQ_DAC;
            `PICK_OFFS: state_next = SEQ_OFFSET;
            default:    state_next = SEQ_GAIN;
          endcase
        end else if (conv_start_i) begin
          state_next = SEQ_CONV;
          cnt_next   = CONV_LAST;
        end
      end
      SEQ_CONV: begin
        if (last) begin
          state_next  = SEQ_IDLE;
          conv_done_o = 1'b1;
        end
      end
      SEQ_DAC: begin
        if (last) begin
          state_next = SEQ_GAIN;
          cnt_next   = STEP_LAST;
        end
      end
      SEQ_GAIN: begin
        if (last && !pick_reg[1]) begin
          state_next = SEQ_OFFSET;
          cnt_next   = STEP_LAST;
        end else if (last) begin
          state_next = SEQ_IDLE;
          cal_done_o = 1'b1;
        end
      end
      SEQ_OFFSET: begin
        if (last) begin
          state_next = SEQ_IDLE;
          cal_done_o = 1'b1;
        end
      end
      default: begin
        state_next = SEQ_IDLE;
      end
    endcase
    busy_next = (state_next != SEQ_IDLE);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= SEQ_IDLE;
      cnt_reg   <= '0;
      pick_reg  <= 2'b00;
      busy_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      pick_reg  <= pick_next;
      busy_reg  <= busy_next;
    end
  end

  assign state_o = state_reg;
  assign busy_o  = busy_reg;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  full_order_a: assert property (
    state_reg == SEQ_DAC && last |=> state_reg == SEQ_GAIN)
    else $error("dac step not followed by gain");
  offset_only_a: assert property (
    state_reg == SEQ_IDLE && cal_start_i && cal_pick_i == `PICK_OFFS
    |=> state_reg == SEQ_OFFSET)
    else $error("offset-only calibration took wrong first step");
  gain_only_a: assert property (
    state_reg == SEQ_GAIN && last && pick_reg == `PICK_GAIN
    |=> state_reg == SEQ_IDLE)
    else $error("gain-only calibration ran past gain");
endmodule
`default_nettype wire

/* adc_control_status_regs.sv */
// control and status register logic of the serial sampling converter
// Behaviour
// - power field plus sleep pin selects power-down
// - read-target field picks returned register
// - mode bit one drives data on input pin
// - mode bit cleared after each read cycle
// - conversion go starts conversion, clears when done
// - kind bit picks self or system calibration
// - calibration go starts calibration, clears when done
// - go low: pick addresses coefficient registers
// - self pick 00: dac, gain, offset
// - self picks: gain+offset, offset, gain
// - system pick 00: dac, gain, offset
// - system picks: gain+offset, offset, gain
// - status returned only with read target 11
// - status reads all zero after power-up
// - status low byte mirrors control fields, but bit four reads zero
// - sixteen-bit frames, target 11, latch at end
// - read targets result, test, coefficients, status
// - busy bit fourteen, zero bits stay zero
// - status go bit high while calibrating
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defines.svh"
module adc_control_status_regs
  import adc_ctrl_pkg::*;
#(
  parameter int CONV_CYCLES = `CONV_CYCLES,
  parameter int STEP_CYCLES = `CAL_STEP_CYCLES
) (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // serial pins
  input  wire logic        sclk_i,
  input  wire logic        frame_n_i,
  input  wire logic        din_i,
  output logic             din_o,
  output logic             din_oe_o,
  output logic             dout_o,
  // power pin and converter side
  input  wire logic        sleep_n_i,
  input  wire logic [11:0] conv_result_i,
  output logic [2:0]       power_down_mode_o,
  output logic             busy_o,
  output logic             cal_system_o,
  output seq_state_t       activity_o
);
  // pin synchronisers: {sclk, frame_n, din, sleep_n}
  logic [3:0]    pin_meta_reg, pin_meta_next;
  logic [3:0]    pin_sync_reg, pin_sync_next;
  logic [1:0]    pin_prev_reg, pin_prev_next;
  logic          frame_on;
  logic          sclk_rise;
  logic          sclk_fall;
  logic          frame_start;
  logic          frame_end;
  // frame engine
  logic [4:0]    bit_cnt_reg, bit_cnt_next;
  logic [15:0]   in_shift_reg, in_shift_next;
  logic [15:0]   out_shift_reg, out_shift_next;
  logic          din_drive_reg, din_drive_next;
  logic [15:0]   word;
  logic          frame_done;
  // register file
  control_word_t ctrl_reg, ctrl_next;
  control_word_t wr_ctrl;
  logic [13:0]   test_reg, test_next;
  logic [13:0]   coef_reg [4];
  logic [13:0]   coef_next [4];
  logic [1:0]    pick;
  logic [1:0]    read_sel;
  status_word_t  status;
  logic [15:0]   read_word;
  logic          keep_conv;
  logic          keep_cal;
  logic [2:0]    pd_reg, pd_next;
  logic          cal_sys_reg, cal_sys_next;
  // sequencer link
  logic          conv_start;
  logic          cal_start;
  logic          conv_done;
  logic          cal_done;
  logic          seq_busy;
  seq_state_t    seq_state;

  // pin sampling and edges
  always_comb begin
    pin_meta_next = {sclk_i, frame_n_i, din_i, sleep_n_i};
    pin_sync_next = pin_meta_reg;
    pin_prev_next = pin_sync_reg[3:2];
    frame_on      = ~pin_sync_reg[2];
    sclk_rise     = frame_on & pin_sync_reg[3] & ~pin_prev_reg[1];
    sclk_fall     = frame_on & ~pin_sync_reg[3] & pin_prev_reg[1];
    frame_start   = ~pin_sync_reg[2] & pin_prev_reg[0];
    frame_end     = pin_sync_reg[2] & ~pin_prev_reg[0];
  end

  // frame engine
  always_comb begin
    bit_cnt_next   = bit_cnt_reg;
    in_shift_next  = in_shift_reg;
    out_shift_next = out_shift_reg;
    din_drive_next = din_drive_reg;
    word           = {in_shift_reg[14:0], pin_sync_reg[1]};
    frame_done     = sclk_rise && (bit_cnt_reg == `FRAME_LAST);
    if (frame_start) begin
      bit_cnt_next   = 5'd0;
      out_shift_next = read_word;
      din_drive_next = ctrl_reg.iface_mode1;
    end else if (frame_end) begin
      din_drive_next = 1'b0;
    end else begin
      if (sclk_rise && bit_cnt_reg != `FRAME_BITS) begin
        in_shift_next = word;
        bit_cnt_next  = bit_cnt_reg + 5'd1;
      end
      if (sclk_fall) begin
        out_shift_next = {out_shift_reg[14:0], 1'b0};
      end
    end
  end

  // read selection and status word
  always_comb begin
    pick     = {ctrl_reg.calibration_pick_hi, ctrl_reg.calibration_pick_lo};
    read_sel = {ctrl_reg.read_target_hi, ctrl_reg.read_target_lo};
    status   = status_word_t'(`STATUS_RESET);
    status.busy                = seq_busy;
    status.power_mode_sel_hi   = ctrl_reg.power_mode_sel_hi;
    status.power_mode_sel_lo   = ctrl_reg.power_mode_sel_lo;
    status.read_target_hi      = ctrl_reg.read_target_hi;
    status.read_target_lo      = ctrl_reg.read_target_lo;
    status.iface_mode1         = ctrl_reg.iface_mode1;
    status.calibration_kind    = ctrl_reg.calibration_kind;
    status.calibration_pick_hi = ctrl_reg.calibration_pick_hi;
    status.calibration_pick_lo = ctrl_reg.calibration_pick_lo;
    status.calibration_go      = ctrl_reg.calibration_go;
    case (read_sel)
      `RD_RESULT: read_word = {4'h0, conv_result_i};
      `RD_TEST:   read_word = {2'b00, test_reg};
      `RD_CAL:    read_word = {2'b00, coef_reg[pick]};
      default:    read_word = status;
    endcase
  end

  // control word, test and coefficient writes
  always_comb begin
    ctrl_next    = ctrl_reg;
    test_next    = test_reg;
    coef_next    = coef_reg;
    cal_sys_next = cal_sys_reg;
    conv_start   = 1'b0;
    cal_start    = 1'b0;
    wr_ctrl      = control_word_t'(word[`DATA_MSB:0]);
    keep_conv    = ctrl_reg.single_conversion_go & ~conv_done;
    keep_cal     = ctrl_reg.calibration_go & ~cal_done;
    ctrl_next.single_conversion_go = keep_conv;
    ctrl_next.calibration_go       = keep_cal;
    if (frame_done) begin
      ctrl_next.iface_mode1 = 1'b0;
      if (!din_drive_reg) begin
        case (word[`TGT_HI_BIT:`TGT_LO_BIT])
          `TGT_CTRL: begin
            ctrl_next       = wr_ctrl;
            ctrl_next.zeros = 4'h0;
            if (!seq_busy) begin
              cal_start  = wr_ctrl.calibration_go;
              conv_start = wr_ctrl.single_conversion_go
                           & ~wr_ctrl.calibration_go;
              ctrl_next.calibration_go       = cal_start;
              ctrl_next.single_conversion_go = conv_start;
            end else begin
              ctrl_next.calibration_go       = keep_cal;
              ctrl_next.single_conversion_go = keep_conv;
            end
            if (cal_start) begin
              cal_sys_next = wr_ctrl.calibration_kind;
            end
          end
          `TGT_TEST: begin
            test_next = word[`DATA_MSB:0];
          end
          `TGT_CAL: begin
            if (!ctrl_reg.calibration_go) begin
              coef_next[pick] = word[`DATA_MSB:0];
            end
          end
          default: begin
            test_next = test_reg;
          end
        endcase
      end
    end
    pd_next = {~pin_sync_reg[0], ctrl_reg.power_mode_sel_hi,
               ctrl_reg.power_mode_sel_lo};
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta_reg  <= 4'hf;
      pin_sync_reg  <= 4'hf;
      pin_prev_reg  <= 2'h3;
      bit_cnt_reg   <= 5'd0;
      in_shift_reg  <= 16'h0000;
      out_shift_reg <= 16'h0000;
      din_drive_reg <= 1'b0;
      ctrl_reg      <= control_word_t'(`CTRL_RESET);
      test_reg      <= `TEST_RESET;
      pd_reg        <= 3'h0;
      cal_sys_reg   <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        coef_reg[i] <= `COEF_RESET;
      end
    end else begin
      pin_meta_reg  <= pin_meta_next;
      pin_sync_reg  <= pin_sync_next;
      pin_prev_reg  <= pin_prev_next;
      bit_cnt_reg   <= bit_cnt_next;
      in_shift_reg  <= in_shift_next;
      out_shift_reg <= out_shift_next;
      din_drive_reg <= din_drive_next;
      ctrl_reg      <= ctrl_next;
      test_reg      <= test_next;
      pd_reg        <= pd_next;
      cal_sys_reg   <= cal_sys_next;
      coef_reg      <= coef_next;
    end
  end

  activity_sequencer #(
    .CONV_CYCLES (CONV_CYCLES),
    .STEP_CYCLES (STEP_CYCLES),
    .CNT_W       (`SEQ_CNT_W)
  ) u_seq (
    .clk_sys_i    (clk_sys_i),
    .rst_n_i      (rst_n_i),
    .conv_start_i (conv_start),
    .cal_start_i  (cal_start),
    .cal_pick_i   (wr_ctrl[2:1]),
    .state_o      (seq_state),
    .busy_o       (seq_busy),
    .conv_done_o  (conv_done),
    .cal_done_o   (cal_done)
  );

  assign din_o             = out_shift_reg[15];
  assign din_oe_o          = din_drive_reg;
  assign dout_o            = out_shift_reg[15];
  assign power_down_mode_o = pd_reg;
  assign busy_o            = seq_busy;
  assign cal_system_o      = cal_sys_reg;
  assign activity_o        = seq_state;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  mode_clear_a: assert property (
    frame_done && (din_drive_reg || word[15:14] != `TGT_CTRL)
    |=> !ctrl_reg.iface_mode1)
    else $error("mode bit survived a read cycle");
  conv_clear_a: assert property (
    conv_done |=> !ctrl_reg.single_conversion_go)
    else $error("conversion go not cleared at end");
  cal_track_a: assert property (
    ctrl_reg.calibration_go ==
      (seq_state inside {SEQ_DAC, SEQ_GAIN, SEQ_OFFSET}))
    else $error("calibration go bit disagrees with activity");
  zero_bits_a: assert property (
    status.zero_top == 1'b0 && status.zeros == 4'h0
    && status.busy == (seq_state != SEQ_IDLE))
    else $error("status zero or busy bits wrong");
  status_read_a: assert property (
    frame_start && read_sel == `RD_STATUS
    |=> out_shift_reg == $past(status))
    else $error("status word not loaded for read");
  result_read_a: assert property (
    frame_start && read_sel == `RD_RESULT
    |=> out_shift_reg[15:12] == 4'h0)
    else $error("result read lacks leading zeros");
  ctrl_latch_a: assert property (
    frame_done && !din_drive_reg && word[15:14] == `TGT_CTRL
    |=> read_sel == $past(word[7:6]) && ctrl_reg.zeros == 4'h0)
    else $error("control write not latched");
  power_mode_a: assert property (
    ##1 pd_reg == {~$past(pin_sync_reg[0]),
                   $past(ctrl_reg.power_mode_sel_hi),
                   $past(ctrl_reg.power_mode_sel_lo)})
    else $error("power-down mode not tracking inputs");
  coef_guard_a: assert property (
    ctrl_reg.calibration_go |-> coef_next[pick] == coef_reg[pick])
    else $error("coefficient written during calibration");

  conv_run_c: cover property (conv_start ##[1:1000] conv_done);
  full_cal_c: cover property (
    seq_state == SEQ_DAC ##1 seq_state == SEQ_GAIN);
  status_rd_c: cover property (frame_start && read_sel == `RD_STATUS);
  mode1_rd_c: cover property (frame_done && din_drive_reg);
endmodule
`default_nettype wire

/* host_serial_model.sv */
// host side of the serial link: framed sixteen-bit transfers
`timescale 1ns/1ps
`default_nettype none
module host_serial_model #(
  parameter int HALF = 6
) (
  // clock
  input  wire logic clk_sys_i,
  // device outputs
  input  wire logic din_o,
  input  wire logic din_oe_o,
  input  wire logic dout_o,
  // host pins
  output logic      frame_n_o,
  output logic      sclk_o,
  output logic      din_line_o
);
  logic host_din;

  // shared data pin, device wins while it drives
  assign din_line_o = din_oe_o ? din_o : host_din;

  initial begin
    frame_n_o = 1'b1;
    sclk_o = 1'b1;
    host_din = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  // msb first, host samples on each sclk rise
  task automatic transfer(input logic [15:0] w, input int nbits,
                          output logic [15:0] r, output logic oe);
    r = 16'h0000;
    oe = 1'b0;
    wait_clk(1);
    frame_n_o = 1'b0;
    sclk_o = 1'b0;
    host_din = w[15];
    wait_clk(HALF + 2);
    for (int i = 15; i >= 16 - nbits; i--) begin
      sclk_o = 1'b1;
      r[i] = din_oe_o ? din_o : dout_o;
      oe = oe | din_oe_o;
      wait_clk(HALF);
      if (i > 16 - nbits) begin
        sclk_o = 1'b0;
        host_din = w[i-1];
        wait_clk(HALF);
      end
    end
    frame_n_o = 1'b1;
    // released line no longer shows the last bit
    host_din = ~host_din;
    wait_clk(4);
  endtask
endmodule
`default_nettype wire

/* adc_control_status_regs_test.sv */
// self-checking bench of the converter control and status registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) check((g) === (e), m)
module adc_control_status_regs_test
  import adc_ctrl_pkg::*;
;
  localparam int CONV_N = 16;
  localparam int STEP_N = 80;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        sclk, frame_n, din_line, din_o, din_oe, dout;
  logic        sleep_n = 1'b1;
  logic [11:0] conv_result = 12'h000;
  logic [2:0]  pdm;
  logic        busy, cal_sys;
  seq_state_t  activity;
  int          errors = 0;
  int          comparisons = 0;
  int          seed = 32'h15cb7f41;
  logic [15:0] rd;
  logic        oe;
  logic [5:0]  cal_low;
  logic [13:0] coef [4];
  seq_state_t  last_state = SEQ_IDLE;
  int          run_len = 0;
  seq_state_t  seen_q [$];
  int          len_q [$];

  always #2.5 clk_sys_i = ~clk_sys_i;

  adc_control_status_regs #(.CONV_CYCLES(CONV_N), .STEP_CYCLES(STEP_N))
  u_adc_control_status_regs (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sclk_i(sclk),
    .frame_n_i(frame_n), .din_i(din_line), .din_o(din_o),
    .din_oe_o(din_oe), .dout_o(dout), .sleep_n_i(sleep_n),
    .conv_result_i(conv_result), .power_down_mode_o(pdm),
    .busy_o(busy), .cal_system_o(cal_sys), .activity_o(activity));

  host_serial_model u_host_serial_model (
    .clk_sys_i(clk_sys_i), .din_o(din_o), .din_oe_o(din_oe),
    .dout_o(dout), .frame_n_o(frame_n), .sclk_o(sclk),
    .din_line_o(din_line));

  // records each busy step and its length
  always @(posedge clk_sys_i) begin
    if (activity !== last_state) begin
      if (last_state != SEQ_IDLE) begin
        seen_q.push_back(last_state);
        len_q.push_back(run_len);
      end
      last_state = activity;
      run_len = 1;
    end else run_len++;
  end

  function automatic logic [15:0] ctrl(input logic [1:0] pm, rt,
                                       input logic [5:0] low);
    return {2'b11, 4'h0, pm, rt, low};
  endfunction

  function automatic logic [15:0] stat(input logic bsy,
                                       input logic [1:0] pm,
                                       input logic [5:0] low);
    return {1'b0, bsy, 4'h0, pm, 2'b11, low[5], 1'b0, low[3:0]};
  endfunction

  task automatic check(input bit ok, input string msg);
    comparisons++;
    if (!ok) begin
      errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic summarize();
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic xfer(input logic [15:0] w, input int nbits = 16);
    u_host_serial_model.transfer(w, nbits, rd, oe);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    if (n >= 3000) begin
      errors++;
      $display("MISMATCH %0t busy stuck", $time);
      summarize();
    end
  endtask

  task automatic check_steps(input logic [1:0] pick);
    seq_state_t exp_q [$];
    case (pick)
      2'b00: exp_q = '{SEQ_DAC, SEQ_GAIN, SEQ_OFFSET};
      2'b01: exp_q = '{SEQ_GAIN, SEQ_OFFSET};
      2'b10: exp_q = '{SEQ_OFFSET};
      default: exp_q = '{SEQ_GAIN};
    endcase
    `CHK(seen_q.size(), exp_q.size(), "step count");
    foreach (exp_q[i]) begin
      `CHK(seen_q[i], exp_q[i], "step order");
      `CHK(len_q[i], STEP_N, "step length");
    end
  endtask

  initial begin
    repeat (20) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    `CHK(pdm, 3'h0, "power after reset");
    `CHK(busy, 1'b0, "busy after reset");
    `CHK(activity, SEQ_IDLE, "idle after reset");
    conv_result = 12'($random(seed));
    xfer({2'b00, 14'h3fff});
    `CHK(rd, {4'h0, conv_result}, "default result read");
    xfer(ctrl(2'b00, 2'b11, 6'h00));
    xfer(16'h0000);
    `CHK(rd, stat(1'b0, 2'b00, 6'h00), "status after reset");
    for (int p = 0; p < 4; p++) begin
      xfer(ctrl(p[1:0], 2'b11, 6'h00));
      sleep_n = p[0];
      repeat (6) @(posedge clk_sys_i);
      #1;
      `CHK(pdm, {~p[0], p[1:0]}, "power field");
      xfer(16'h0000);
      `CHK(rd, stat(1'b0, p[1:0], 6'h00), "power status");
    end
    // aborted frame must not land
    xfer(ctrl(2'b00, 2'b00, 6'h0e), 10);
    xfer(16'h0000);
    `CHK(rd, stat(1'b0, 2'b11, 6'h00), "short frame");
    xfer(ctrl(2'b00, 2'b11, 6'h20));
    xfer(ctrl(2'b01, 2'b00, 6'h00));
    `CHK(oe, 1'b1, "data pin driven");
    `CHK(rd, stat(1'b0, 2'b00, 6'h20), "mode bit set");
    xfer(16'h0000);
    `CHK(oe, 1'b0, "data pin released");
    `CHK(rd, stat(1'b0, 2'b00, 6'h00), "mode bit cleared");
    for (int p = 0; p < 4; p++) begin
      coef[p] = 14'($random(seed));
      xfer(ctrl(2'b00, 2'b11, {3'b000, p[1:0], 1'b0}));
      xfer({2'b10, coef[p]});
    end
    for (int p = 0; p < 4; p++) begin
      xfer(ctrl(2'b00, 2'b10, {3'b000, p[1:0], 1'b0}));
      xfer(16'h0000);
      `CHK(rd, {2'b00, coef[p]}, "coefficient read");
    end
    // coefficient write during a full calibration must not land
    xfer(ctrl(2'b00, 2'b10, 6'h01));
    xfer({2'b10, ~coef[0]});
    wait_idle();
    xfer(ctrl(2'b00, 2'b10, 6'h00));
    xfer(16'h0000);
    `CHK(rd, {2'b00, coef[0]}, "coefficient kept");
    coef[0] = 14'($random(seed));
    xfer({2'b01, coef[0]});
    xfer(ctrl(2'b00, 2'b01, 6'h00));
    xfer(16'h0000);
    `CHK(rd, {2'b00, coef[0]}, "test register read");
    seen_q.delete();
    len_q.delete();
    xfer(ctrl(2'b00, 2'b11, 6'h10));
    wait_idle();
    xfer(16'h0000);
    `CHK(rd, stat(1'b0, 2'b00, 6'h00), "conversion done");
    `CHK(seen_q.size(), 1, "conversion steps");
    `CHK(seen_q[0], SEQ_CONV, "conversion state");
    `CHK(len_q[0], CONV_N, "conversion length");
    for (int c = 0; c < 8; c++) begin
      seen_q.delete();
      len_q.delete();
      cal_low = {2'b00, c[2:0], 1'b1};
      xfer(ctrl(2'b00, 2'b11, cal_low));
      xfer(16'h0000);
      `CHK(rd, stat(1'b1, 2'b00, cal_low), "busy status");
      `CHK(cal_sys, c[2], "calibration kind");
      wait_idle();
      xfer(16'h0000);
      `CHK(rd, stat(1'b0, 2'b00, cal_low - 6'h01), "go cleared");
      check_steps(c[1:0]);
    end
    summarize();
  end
endmodule
`default_nettype wire
